// [pcs_core.sv]
// Program counter, hardware stack, core special registers and status flags
module pcs_core (
  input  wire logic        ref_clk_in,           // 40 MHz system clock
  input  wire logic        rst_n_in,             // Synchronous reset, active low
  input  wire logic [10:0] avs_address_in,       // Byte address
  input  wire logic        avs_read_in,          // Read request
  input  wire logic        avs_write_in,         // Write request
  input  wire logic [31:0] avs_writedata_in,     // Write data
  input  wire logic [3:0]  avs_byteenable_in,    // Byte lanes
  output logic      [31:0] avs_readdata_out,     // Read data
  output logic             avs_waitrequest_out,  // Low marks the answer
  output logic      [11:0] prog_addr_out,        // Program store word address
  output logic             irq_enable_out,       // Global interrupt enable
  output logic             special_bank_out,     // Special register bank
  output logic      [2:0]  general_bank_out      // General register bank
);

  pcs_pkg::pcs_bus_type          bus_state;
  logic [2:0]                    cnt;
  logic [8:0]                    l_idx;
  logic                          l_wr;
  logic [31:0]                   l_data;
  logic [3:0]                    l_be;

  logic [pcs_pkg::PC_W-1:0]      pc;
  logic [pcs_pkg::PC_W-1:0]      stack [pcs_pkg::STACK_DEPTH];
  logic [$clog2(pcs_pkg::STACK_DEPTH)-1:0] sp;
  logic [7:0]                    acc;
  logic [7:0]                    ind_ptr;
  logic                          sbs;
  logic [2:0]                    gbs;
  logic                          gie;
  logic                          flag_to;
  logic                          flag_pd;
  logic                          flag_z;
  logic                          flag_dc;
  logic                          flag_c;
  logic [7:0]                    gp_mem [pcs_pkg::GP_MEM_N];

  logic                          perform;
  logic                          is_map;
  logic [7:0]                    ea;
  logic                          wr_map;
  logic                          exec;
  pcs_pkg::pcs_op_type           op;
  logic [pcs_pkg::OPND_W-1:0]    opnd;
  logic [pcs_pkg::PC_W-1:0]      pc_inc;
  logic [pcs_pkg::PC_W-1:0]      stack_top;
  logic                          gp_hit;
  logic [10:0]                   gp_slot;
  logic [7:0]                    status_byte;
  logic [7:0]                    map_rd;
  logic [31:0]                   next_readdata;
  logic [8:0]                    alu_sum;
  logic [4:0]                    alu_half;
  logic [2:0]                    req_cnt;
  pcs_pkg::pcs_op_type           req_op;

  assign req_op = pcs_pkg::pcs_op_type'(avs_writedata_in[3:0]);

  // Cost of a request in clocks, minus one
  always_comb begin
    req_cnt = pcs_pkg::CNT_REG;
    if (avs_write_in && avs_address_in[10:2] == pcs_pkg::IDX_CMD
        && avs_byteenable_in == 4'hF) begin
      if (req_op == pcs_pkg::OP_FAR_JUMP || req_op == pcs_pkg::OP_FAR_CALL) begin
        req_cnt = pcs_pkg::CNT_FAR;
      end else begin
        req_cnt = pcs_pkg::CNT_INSN;
      end
    end
  end

  // Bus slave sequencing; waitrequest stays high except in the answer cycle
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      bus_state           <= pcs_pkg::BUS_IDLE;
      cnt                 <= 3'h0;
      l_idx               <= 9'h000;
      l_wr                <= 1'b0;
      l_data              <= 32'h00000000;
      l_be                <= 4'h0;
      avs_waitrequest_out <= 1'b1;
    end else begin
      case (bus_state)
        pcs_pkg::BUS_IDLE: begin
          if (avs_read_in || avs_write_in) begin
            l_idx     <= avs_address_in[10:2];
            l_wr      <= avs_write_in;
            l_data    <= avs_writedata_in;
            l_be      <= avs_byteenable_in;
            cnt       <= req_cnt;
            bus_state <= pcs_pkg::BUS_BUSY;
          end
        end
        pcs_pkg::BUS_BUSY: begin
          if (cnt == 3'h0) begin
            avs_waitrequest_out <= 1'b0;
            bus_state           <= pcs_pkg::BUS_ACK;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        pcs_pkg::BUS_ACK: begin
          avs_waitrequest_out <= 1'b1;
          bus_state           <= pcs_pkg::BUS_IDLE;
        end
        default: begin
          avs_waitrequest_out <= 1'b1;
          bus_state           <= pcs_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Decode of the latched request
  always_comb begin
    perform = (bus_state == pcs_pkg::BUS_BUSY) && (cnt == 3'h0);
    is_map  = (l_idx[8] == 1'b0);
    op      = pcs_pkg::pcs_op_type'(l_data[3:0]);
    opnd    = l_data[pcs_pkg::CMD_OPND_LSB +: pcs_pkg::OPND_W];
    // Pointer pointing at the port itself lands on the port again: reads zero
    ea      = (l_idx == pcs_pkg::IDX_INDIRECT) ? ind_ptr : l_idx[7:0];
    wr_map  = perform && l_wr && is_map && l_be[0];
    exec    = perform && l_wr && (l_idx == pcs_pkg::IDX_CMD) && (l_be == 4'hF);
    pc_inc  = pc + 14'h0001;
    stack_top = stack[sp - 3'h1];
    alu_sum   = {1'b0, acc} + {1'b0, opnd[7:0]};
    alu_half  = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
  end

  // General purpose store: common 0x50..0x7F, banked 0x80..0xFF
  always_comb begin
    gp_hit  = (ea >= pcs_pkg::GP_COMMON_LO);
    gp_slot = 11'h000;
    if (ea >= pcs_pkg::GP_BANKED_LO) begin
      gp_slot = 11'(pcs_pkg::GP_COMMON_N) + {1'b0, gbs, ea[6:0]};
    end else if (gp_hit) begin
      gp_slot = {3'h0, ea - pcs_pkg::GP_COMMON_LO};
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (wr_map && gp_hit) begin
      gp_mem[gp_slot] <= l_data[7:0];
    end
  end

  assign status_byte = {gie, 2'b00, flag_to, flag_pd, flag_z, flag_dc, flag_c};

  // Read side of the data map and own registers
  always_comb begin
    map_rd = 8'h00;
    case (ea)
      pcs_pkg::IDX_BANK[7:0]:    map_rd = {3'h0, sbs, 1'b0, gbs};
      pcs_pkg::IDX_PCL[7:0]:     map_rd = pc[7:0];
      pcs_pkg::IDX_STATUS[7:0]:  map_rd = status_byte;
      pcs_pkg::IDX_POINTER[7:0]: map_rd = ind_ptr;
      default: begin
        if (gp_hit) begin
          map_rd = gp_mem[gp_slot];
        end
      end
    endcase
    next_readdata = 32'h00000000;
    if (is_map) begin
      next_readdata = {24'h000000, map_rd};
    end else if (l_idx == pcs_pkg::IDX_PC_FULL) begin
      next_readdata = {13'h0000, sp, 2'b00, pc};
    end else if (l_idx == pcs_pkg::IDX_ACC) begin
      next_readdata = {24'h000000, acc};
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (perform) begin
      avs_readdata_out <= l_wr ? 32'h00000000 : next_readdata;
    end
  end

  // Program counter
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pc <= pcs_pkg::PC_RESET;
    end else if (exec) begin
      case (op)
        pcs_pkg::OP_NEAR_JUMP,
        pcs_pkg::OP_NEAR_CALL:  pc <= {pc[13:12], opnd[11:0]};
        // Counter is only fourteen bits, so the top operand bit is dropped
        pcs_pkg::OP_FAR_JUMP,
        pcs_pkg::OP_FAR_CALL,
        pcs_pkg::OP_IRQ_ACCEPT: pc <= opnd[13:0];
        pcs_pkg::OP_RET,
        pcs_pkg::OP_POP_WITH_LITERAL_INSN,
        pcs_pkg::OP_POP_FROM_IRQ_INSN:       pc <= stack_top;
        pcs_pkg::OP_ADD_PCL:    pc <= pc + {6'h00, acc};
        default:                pc <= pc_inc;
      endcase
    end else if (wr_map && ea == pcs_pkg::IDX_PCL[7:0]) begin
      pc[7:0] <= l_data[7:0];
    end
  end

  // Circular stack: overflow overwrites the oldest entry
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sp <= '0;
    end else if (exec) begin
      case (op)
        pcs_pkg::OP_NEAR_CALL,
        pcs_pkg::OP_FAR_CALL,
        pcs_pkg::OP_IRQ_ACCEPT: begin
          stack[sp] <= pc_inc;
          sp        <= sp + 3'h1;
        end
        pcs_pkg::OP_RET,
        pcs_pkg::OP_POP_WITH_LITERAL_INSN,
        pcs_pkg::OP_POP_FROM_IRQ_INSN: begin
          sp <= sp - 3'h1;
        end
        default: begin
          sp <= sp;
        end
      endcase
    end
  end

  // Accumulator
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      acc <= pcs_pkg::BYTE_RESET;
    end else if (exec && op == pcs_pkg::OP_POP_WITH_LITERAL_INSN) begin
      acc <= opnd[7:0];
    end else if (exec && op == pcs_pkg::OP_ALU_ADD) begin
      acc <= alu_sum[7:0];
    end else if (perform && l_wr && l_idx == pcs_pkg::IDX_ACC && l_be[0]) begin
      acc <= l_data[7:0];
    end
  end

  // Bank select and indirect pointer
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sbs     <= 1'b0;
      gbs     <= 3'h0;
      ind_ptr <= pcs_pkg::BYTE_RESET;
    end else if (wr_map) begin
      if (ea == pcs_pkg::IDX_BANK[7:0]) begin
        sbs <= l_data[pcs_pkg::BANK_SPECIAL];
        gbs <= l_data[2:0];
      end
      if (ea == pcs_pkg::IDX_POINTER[7:0]) begin
        ind_ptr <= l_data[7:0];
      end
    end
  end

  // Interrupt enable; read-only from the data map
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      gie <= 1'b0;
    end else if (exec && op == pcs_pkg::OP_IRQ_EN) begin
      gie <= 1'b1;
    end else if (exec && (op == pcs_pkg::OP_IRQ_DIS || op == pcs_pkg::OP_IRQ_ACCEPT)) begin
      gie <= 1'b0;
    end
  end

  // Time-out and power-down flags; reset stands for power-up
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      flag_to <= pcs_pkg::FLAG_PWR_ON;
      flag_pd <= pcs_pkg::FLAG_PWR_ON;
    end else if (exec && op == pcs_pkg::OP_POWER_DOWN) begin
      flag_to <= 1'b1;
      flag_pd <= 1'b0;
    end else if (exec && op == pcs_pkg::OP_WDT_CLEAR) begin
      flag_to <= 1'b1;
      flag_pd <= 1'b1;
    end else if (exec && op == pcs_pkg::OP_WDT_TIMEOUT) begin
      flag_to <= 1'b0;
    end else if (wr_map && ea == pcs_pkg::IDX_STATUS[7:0]) begin
      flag_to <= l_data[pcs_pkg::ST_TO];
      flag_pd <= l_data[pcs_pkg::ST_PD];
    end
  end

  // Arithmetic flags
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      flag_z  <= 1'b0;
      flag_dc <= 1'b0;
      flag_c  <= 1'b0;
    end else if (exec && op == pcs_pkg::OP_ALU_ADD) begin
      flag_z  <= (alu_sum[7:0] == 8'h00);
      flag_dc <= alu_half[4];
      flag_c  <= alu_sum[8];
    end else if (wr_map && ea == pcs_pkg::IDX_STATUS[7:0]) begin
      flag_z  <= l_data[pcs_pkg::ST_Z];
      flag_dc <= l_data[pcs_pkg::ST_DC];
      flag_c  <= l_data[pcs_pkg::ST_C];
    end
  end

  // Registered copies for the pins
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      prog_addr_out    <= 12'h000;
      irq_enable_out   <= 1'b0;
      special_bank_out <= 1'b0;
      general_bank_out <= 3'h0;
    end else begin
      prog_addr_out    <= pc[pcs_pkg::PROG_ADDR_W-1:0];
      irq_enable_out   <= gie;
      special_bank_out <= sbs;
      general_bank_out <= gbs;
    end
  end

endmodule : pcs_core

// [pcs_core_chk.sv]
// Bus timing and core output checks for the sequencing core
module pcs_core_chk (
  input wire logic        ref_clk_in,          // Clock
  input wire logic        rst_n_in,            // Reset, active low
  input wire logic [10:0] avs_address_in,      // Byte address
  input wire logic        avs_read_in,         // Read
  input wire logic        avs_write_in,        // Write
  input wire logic [31:0] avs_writedata_in,    // Write data
  input wire logic [3:0]  avs_byteenable_in,   // Lanes
  input wire logic [31:0] avs_readdata_out,    // Read data
  input wire logic        avs_waitrequest_out, // Wait
  input wire logic [11:0] prog_addr_out,       // Program address
  input wire logic        irq_enable_out,      // Interrupt enable
  input wire logic        special_bank_out,    // Special bank
  input wire logic [2:0]  general_bank_out     // General bank
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic       cmd;
  logic       far;
  logic [3:0] op;
  assign op  = avs_writedata_in[3:0];
  assign cmd = avs_write_in && avs_address_in[10:2] == pcs_pkg::IDX_CMD
               && avs_byteenable_in == 4'hF;
  assign far = cmd && (op == pcs_pkg::OP_FAR_JUMP || op == pcs_pkg::OP_FAR_CALL);
  property p_near_jump;
    logic [11:0] t;
    ($rose(avs_write_in) && cmd && op == pcs_pkg::OP_NEAR_JUMP, t = avs_writedata_in[27:16])
      |-> ##4 prog_addr_out == t;
  endproperty
  property p_bank;
    logic [4:0] t;
    ($rose(avs_write_in) && avs_address_in[10:2] == pcs_pkg::IDX_BANK && avs_byteenable_in[0],
     t = avs_writedata_in[4:0]) |-> ##3 {special_bank_out, general_bank_out} == {t[4], t[2:0]};
  endproperty
  a_reg_latency: assert property (($rose(avs_read_in) || ($rose(avs_write_in) && !cmd))
    |-> avs_waitrequest_out [*2] ##1 !avs_waitrequest_out) else $error("register answer late");
  // Exact latencies: one clock to take, two clocks per instruction cycle
  a_near_latency: assert property ($rose(avs_write_in) && cmd && !far
    |-> avs_waitrequest_out [*3] ##1 !avs_waitrequest_out) else $error("near answer late");
  a_far_latency: assert property ($rose(avs_write_in) && far
    |-> avs_waitrequest_out [*5] ##1 !avs_waitrequest_out) else $error("far answer wrong");
  a_answer_once: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer held");
  a_answer_cause: assert property (!avs_waitrequest_out |-> avs_read_in || avs_write_in)
    else $error("answer without request");
  a_pc_reset: assert property (disable iff (1'b0) !rst_n_in |=> prog_addr_out == 12'h000)
    else $error("counter not cleared");
  a_status_unused: assert property (!avs_waitrequest_out && avs_read_in
    && avs_address_in[10:2] == pcs_pkg::IDX_STATUS |-> avs_readdata_out[6:5] == 2'h0)
    else $error("status bits 6:5 set");
  a_irq_set: assert property ($rose(avs_write_in) && cmd && op == pcs_pkg::OP_IRQ_EN
    |-> ##4 irq_enable_out) else $error("enable not set");
  a_irq_clear: assert property ($rose(avs_write_in) && cmd && (op == pcs_pkg::OP_IRQ_DIS
    || op == pcs_pkg::OP_IRQ_ACCEPT) |-> ##4 !irq_enable_out) else $error("enable kept");
  a_near_target: assert property (p_near_jump) else $error("jump target wrong");
  a_bank_select: assert property (p_bank) else $error("bank outputs wrong");
  c_far: cover property ($rose(avs_write_in) && far);
  c_call: cover property ($rose(avs_write_in) && cmd && op == pcs_pkg::OP_NEAR_CALL);
  c_status: cover property (!avs_waitrequest_out && avs_address_in[10:2] == pcs_pkg::IDX_STATUS);
endmodule : pcs_core_chk

// [pcs_core_test.sv]
// Self-checking bench for the sequencing core with a reference model
module pcs_core_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [10:0] avs_address_in = 11'h000;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0]  avs_byteenable_in = 4'hF;
  logic [31:0] avs_readdata_out, q, rnd;
  logic        avs_waitrequest_out, irq_enable_out, special_bank_out;
  logic [11:0] prog_addr_out;
  logic [2:0]  general_bank_out, sp = 3'h0;
  logic [13:0] pc = 14'h0000;
  logic [13:0] stk [8];
  logic [7:0]  acc = 8'h00;
  logic [7:0]  st = 8'h18;
  logic [14:0] opnd;
  int          err_count, checks_done, n, i, depth;
  int          seed = 32'hDB91;

  always #12.5 ref_clk_in = ~ref_clk_in;

  pcs_core u_pcs_core (.ref_clk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .prog_addr_out, .irq_enable_out, .special_bank_out, .general_bank_out);

  task automatic print_verdict();
    $display("Mismatches %0d of %0d checks", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk

  // Edge first so a released strobe is never raised again in the same step
  task automatic bus(input logic w, input logic [8:0] idx, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge ref_clk_in);
    n = 0;
    avs_address_in <= {idx, 2'b00};
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    // Answer edge: taken before the slave's own update at this edge
    q = avs_readdata_out;
    chk("answer", 32'h0, {31'h0, avs_waitrequest_out});
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus

  task automatic rd(input logic [8:0] idx, input logic [31:0] e, input string nm);
    bus(1'b0, idx, 32'h0, 4'hF);
    chk(nm, e, q);
  endtask : rd

  task automatic cmd(input int op);
    logic [13:0] old;
    logic [8:0]  s;
    int          want;
    opnd = 15'($random(seed));
    if (op inside {5, 6, 7} && depth == 0) op = 0;
    bus(1'b1, 9'h100, {1'b0, opnd, 12'h000, 4'(op)}, 4'hF);
    want = (op inside {3, 4}) ? pcs_pkg::FAR_INSN_CYC : 1;
    chk("insn cycles", 32'(want * pcs_pkg::CLKS_PER_INSN + 2), 32'(n));
    old = pc;
    pc = old + 14'h0001;
    case (op)
      1, 2, 3, 4, 11: begin
        if (op inside {2, 4, 11}) begin
          stk[sp] = pc;
          sp++;
          depth += int'(depth < 8);
        end
        pc = op < 3 ? {old[13:12], opnd[11:0]} : opnd[13:0];
        if (op == 11) st[7] = 1'b0;
      end
      5, 6, 7: begin
        sp--;
        depth--;
        pc = stk[sp];
        if (op == 6) acc = opnd[7:0];
      end
      8: pc = old + 14'(acc);
      9: st[7] = 1'b1;
      10: st[7] = 1'b0;
      12: st[4:3] = 2'b10;
      13: st[4:3] = 2'b11;
      14: st[4] = 1'b0;
      15: begin
        s = acc + opnd[7:0];
        st[2:0] = {s[7:0] == 8'h00, {1'b0, acc[3:0]} + opnd[3:0] > 5'h0F, s[8]};
        acc = s[7:0];
      end
      default: ;
    endcase
  endtask : cmd

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    err_count++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rd(9'h002, 32'h0, "pc low");
    chk("register cycles", 32'h3, 32'(n));
    rd(9'h003, 32'h18, "status");
    rd(9'h005, 32'h0, "absent");
    bus(1'b1, 9'h1FF, 32'hFF, 4'hF);
    rd(9'h1FF, 32'h0, "unmapped");
    bus(1'b1, 9'h001, 32'hFF, 4'hF);
    rd(9'h001, 32'h17, "bank");
    chk("banks", 32'hF, {28'h0, special_bank_out, general_bank_out});
    bus(1'b1, 9'h004, 32'h50, 4'hF);
    bus(1'b1, 9'h000, 32'hA5, 4'hF);
    rd(9'h050, 32'hA5, "via pointer");
    rd(9'h000, 32'hA5, "via port");
    // Same offset in two general banks must keep two bytes
    bus(1'b1, 9'h080, 32'h5A, 4'hF);
    bus(1'b1, 9'h001, 32'h00, 4'hF);
    bus(1'b1, 9'h080, 32'hC3, 4'hF);
    rd(9'h080, 32'hC3, "bank 0 byte");
    bus(1'b1, 9'h001, 32'h07, 4'hF);
    rd(9'h080, 32'h5A, "bank 7 byte");
    bus(1'b1, 9'h002, 32'h3C, 4'h0);
    rd(9'h002, 32'h0, "lane off");
    bus(1'b1, 9'h002, 32'h3C, 4'hF);
    rd(9'h002, 32'h3C, "pc low");
    pc = 14'h003C;
    // Enable bit is read-only from the bus, so writing it must not stick
    bus(1'b1, 9'h003, 32'hE7, 4'hF);
    st = 8'h07;
    rd(9'h003, 32'h07, "status write");
    for (i = 0; i < 64; i++) begin
      rnd = $random(seed);
      bus(1'b1, 9'h102, rnd, 4'hF);
      acc = rnd[7:0];
      if (i % 4 == 1) begin
        bus(1'b1, 9'h002, rnd, 4'hF);
        pc[7:0] = rnd[7:0];
      end
      cmd(i % 16);
      rd(9'h101, {13'h0, sp, 2'h0, pc}, "pc full");
      rd(9'h003, {24'h0, st}, "status");
      rd(9'h102, {24'h0, acc}, "acc");
      chk("prog addr", {20'h0, pc[11:0]}, {20'h0, prog_addr_out});
      chk("irq enable", {31'h0, st[7]}, {31'h0, irq_enable_out});
    end
    // Nine calls overrun the eight entries, so the oldest return is lost
    for (i = 0; i < 18; i++) begin
      cmd(i < 9 ? 2 : 5);
      rd(9'h101, {13'h0, sp, 2'h0, pc}, "pc wrap");
    end
    bus(1'b1, 9'h002, 32'hA5, 4'hF);
    @(posedge ref_clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    pc = 14'h0000;
    sp = 3'h0;
    depth = 0;
    acc = 8'h00;
    st = 8'h18;
    rd(9'h101, {13'h0, sp, 2'h0, pc}, "pc after reset");
    rd(9'h003, {24'h0, st}, "status after reset");
    chk("prog addr after reset", 32'h0, {20'h0, prog_addr_out});
    print_verdict();
  end
endmodule : pcs_core_test

bind pcs_core pcs_core_chk u_chk (.ref_clk_in, .rst_n_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
  .avs_waitrequest_out, .prog_addr_out, .irq_enable_out, .special_bank_out, .general_bank_out);

// [pcs_pkg.sv]
// Constants, register map and instruction encodings for the sequencing core
// Operation
// - Low eight program counter bits are a readable and writable data register.
// - Program counter and every stack entry are fourteen bits wide.
// - Program counter addresses a program store of 4K words of 15 bits.
// - One program page spans 4096 instruction words.
// - Any reset clears the low program counter byte to zero.
// - Near jump loads its target into the lowest twelve counter bits.
// - Near call pushes counter plus one, loads target into lowest twelve bits.
// - Far jump loads its target into all fourteen counter bits.
// - Far call pushes counter plus one, loads target into all fourteen bits.
// - All three return instructions reload the counter from the stack top.
// - Adding the accumulator to the low byte adds to the full counter.
// - Other writes to the low byte replace only the low eight bits.
// - Every instruction but far jump and far call takes one instruction cycle of two clock periods.
// - Far jump and far call each take two instruction cycles.
// - Map: 0x00 indirect port, 0x01 bank select, 0x02 low byte, 0x03 status, 0x04 pointer.
// - Status bit 7 is interrupt enable: enable sets, disable or acceptance clears.
// - Status bit 4 sets on power down, watchdog clear, power up; clears on time-out.
// - Status bit 3 sets on power on or watchdog clear; clears on power down.
// - Status bit 2 sets when an arithmetic or logic result is zero.
// - Status bit 1 is the half carry, bit 0 the carry of arithmetic.
// - Status bits 6 and 5 always read zero.
// - Indirect port accesses the location held by the pointer, stores nothing.
// - Bank select bit 4 picks special bank, bits 2..0 pick general bank.
package pcs_pkg;

  localparam int          PC_W           = 14;
  localparam int          PROG_ADDR_W    = 12;
  localparam int          PROG_WORD_W    = 15;
  localparam int          PAGE_WORDS     = 4096;
  localparam int          STACK_DEPTH    = 8;
  localparam int          OPND_W         = 15;

  // Register indices; byte address on the bus is four times the index
  localparam logic [8:0]  IDX_INDIRECT   = 9'h000;
  localparam logic [8:0]  IDX_BANK       = 9'h001;
  localparam logic [8:0]  IDX_PCL        = 9'h002;
  localparam logic [8:0]  IDX_STATUS     = 9'h003;
  localparam logic [8:0]  IDX_POINTER    = 9'h004;
  localparam logic [8:0]  IDX_CMD        = 9'h100;
  localparam logic [8:0]  IDX_PC_FULL    = 9'h101;
  localparam logic [8:0]  IDX_ACC        = 9'h102;

  localparam logic [7:0]  GP_COMMON_LO   = 8'h50;
  localparam logic [7:0]  GP_BANKED_LO   = 8'h80;
  localparam int          GP_COMMON_N    = 48;
  localparam int          GP_MEM_N       = 1072;

  // Field positions
  localparam int          ST_GIE         = 7;
  localparam int          ST_TO          = 4;
  localparam int          ST_PD          = 3;
  localparam int          ST_Z           = 2;
  localparam int          ST_DC          = 1;
  localparam int          ST_C           = 0;
  localparam int          BANK_SPECIAL   = 4;
  localparam int          CMD_OPND_LSB   = 16;

  // Reset values
  localparam logic [13:0] PC_RESET       = 14'h0000;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam logic        FLAG_PWR_ON    = 1'b1;

  // Timing
  localparam int          CLK_PERIOD_NS  = 25;
  localparam int          INSN_CYCLE_NS  = 2 * CLK_PERIOD_NS;
  localparam int          CLKS_PER_INSN  = (INSN_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          FAR_INSN_CYC   = 2;
  localparam logic [2:0]  CNT_REG        = 3'h0;
  localparam logic [2:0]  CNT_INSN       = 3'(CLKS_PER_INSN - 1);
  localparam logic [2:0]  CNT_FAR        = 3'(FAR_INSN_CYC * CLKS_PER_INSN - 1);

  typedef enum logic [3:0] {
    OP_NOP, OP_NEAR_JUMP, OP_NEAR_CALL, OP_FAR_JUMP, OP_FAR_CALL,
    OP_RET, OP_POP_WITH_LITERAL_INSN, OP_POP_FROM_IRQ_INSN, OP_ADD_PCL, OP_IRQ_EN, OP_IRQ_DIS,
    OP_IRQ_ACCEPT, OP_POWER_DOWN, OP_WDT_CLEAR, OP_WDT_TIMEOUT, OP_ALU_ADD
  } pcs_op_type;

  typedef enum logic [1:0] {
    BUS_IDLE, BUS_BUSY, BUS_ACK
  } pcs_bus_type;

endpackage : pcs_pkg
